/* File: pwm_action_deadband_test.sv */
/* Bench: APB register checks and duty counts of all four levels.
   Assumes pwmad_top and pwmad_chk; limit stays 7 throughout. */
`timescale 1ns/1ps
module pwm_action_deadband_test;
   // ------------------------------
   // Signals and bookkeeping
   // ------------------------------
   logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h0;
   logic [31:0] pwdata = 32'h0, prdata, v;
   logic        pready, pslverr, raw_out_a, raw_out_b, final_out_0, final_out_1;
   logic [31:0] exp_q[$];
   logic [11:0] adr[5] = '{12'h060, 12'h064, 12'h068, 12'h06c, 12'h070};
   logic [31:0] msk[5] = '{32'hfff, 32'hfff, 32'h1, 32'hfff, 32'hfff};
   int          cnt[4] = '{0, 56, 0, 112};
   int          num_errors = 0, num_checks = 0, seed = 45061, r, f;

   always #50 pclk = ~pclk;

   pwmad_top DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .raw_out_a, .raw_out_b, .final_out_0, .final_out_1);

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         num_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic stop_test;
      $display("Checks %0d, errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // Reset is asserted for five edges, released just after one
   task automatic reset;
      presetn <= 1'b0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
   endtask

   // One APB transfer, held until pready is seen high
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
         @(posedge pclk);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      apb(1'b0, a, 32'h0);
   endtask

   // Read data meets its note at the completing edge
   always @(posedge pclk)
      if (psel && penable && !pwrite && pready)
         check(prdata, exp_q.pop_front());

   // High cycles over whole periods, so phase does not matter
   task automatic measure(input int e[4]);
      logic [31:0] n[4] = '{default: 0};
      repeat (28) @(posedge pclk);
      repeat (112)
      begin
         @(posedge pclk);
         n[0] += raw_out_a;
         n[1] += raw_out_b;
         n[2] += final_out_0;
         n[3] += final_out_1;
      end
      foreach (n[i]) check(n[i], e[i]);
   endtask

   task automatic run_case(input logic [31:0] m, ca, cb, wa, wb, input int e[4]);
      apb(1'b1, 12'h058, ca);
      apb(1'b1, 12'h05c, cb);
      apb(1'b1, 12'h060, wa);
      apb(1'b1, 12'h064, wb);
      apb(1'b1, 12'h040, m);
      measure(e);
   endtask

   task automatic db(input logic [31:0] en, rs, fs);
      apb(1'b1, 12'h06c, rs);
      apb(1'b1, 12'h070, fs);
      apb(1'b1, 12'h068, en);
   endtask

   // Watchdog well beyond the expected run of some 2060 cycles
   initial
   begin
      #1_000_000;
      num_errors++;
      stop_test;
   end

   initial
   begin
      reset;
      foreach (adr[i]) rd(adr[i], 32'h0);
      foreach (adr[i])
      begin
         v = $random(seed);
         apb(1'b1, adr[i], v);
         rd(adr[i], v & msk[i]);
      end
      apb(1'b1, 12'h07c, v);
      rd(12'h07c, 32'h0);
      reset;
      apb(1'b1, 12'h050, 32'h7);
      for (int k = 0; k < 4; k++)
         run_case(1, 0, 0, k, k << 2, '{cnt[k], cnt[k], cnt[k], cnt[k]});
      run_case(1, 3, 3, 12'hc83, 12'h8c3, '{70, 70, 70, 70});
      run_case(1, 7, 0, 12'h08e, 12'h803, '{98, 112, 98, 112});
      run_case(1, 3, 3, 12'h023, 12'he03, '{112, 112, 112, 112});
      run_case(3, 3, 3, 12'h023, 12'he03, '{24, 48, 24, 48});
      run_case(1, 3, 3, 12'h083, 12'h002, '{70, 0, 70, 0});
      db(1, 2, 1);
      measure('{70, 0, 42, 84});
      r = {$random(seed)} % 5;
      f = {$random(seed)} % 3;
      db(1, r, f);
      measure('{70, 0, (5 - r) * 14, (5 + f) * 14});
      db(1, 6, 4);
      measure('{70, 0, 0, 112});
      db(0, 6, 4);
      measure('{70, 0, 70, 0});
      stop_test;
   end
endmodule

bind pwmad_top pwmad_chk chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
   .pslverr, .raw_out_a, .raw_out_b, .final_out_0, .final_out_1);

/* File: pwmad_action_gen.sv */
/*
 * One action generator: turns counter events into one raw PWM level.
 * Assumes events are one-cycle pulses on pclk, already gated by mode.
 */
`timescale 1ns/1ps
`include "pwmad_params.svh"

module pwmad_action_gen
#(
   parameter bit PRIO_B = 1'b0
)
(
   // Clock and reset
   input  wire logic                     pclk,
   input  wire logic                     presetn,
   // Events
   input  wire logic                     ev_zero,
   input  wire logic                     ev_limit,
   input  wire logic                     ev_cmpa_up,
   input  wire logic                     ev_cmpa_down,
   input  wire logic                     ev_cmpb_up,
   input  wire logic                     ev_cmpb_down,
   // Action word
   input  wire logic [`PWMAD_ACT_W-1:0]  act_word,
   // Raw level
   output logic                          raw_out
);

   // ----------------------------------------
   // Action decode
   // ----------------------------------------
   function automatic logic apply_act(input logic [1:0] act, input logic cur);
      case (pwmad_pkg::pwmad_action_t'(act))
         pwmad_pkg::PWMAD_ACT_HOLD:   apply_act = cur;
         pwmad_pkg::PWMAD_ACT_TOGGLE: apply_act = ~cur;
         pwmad_pkg::PWMAD_ACT_LOW:    apply_act = 1'b0;
         pwmad_pkg::PWMAD_ACT_HIGH:   apply_act = 1'b1;
         default:                     apply_act = cur;
      endcase
   endfunction

   // Field slices of the action word
   wire logic [1:0] act_on_empty  = act_word[`PWMAD_F_ZERO +: 2];
   wire logic [1:0] act_on_limit  = act_word[`PWMAD_F_LIMIT +: 2];
   wire logic [1:0] act_cmpa_up   = act_word[`PWMAD_F_CAU +: 2];
   wire logic [1:0] act_cmpa_down = act_word[`PWMAD_F_CAD +: 2];
   wire logic [1:0] act_cmpb_up   = act_word[`PWMAD_F_CBU +: 2];
   wire logic [1:0] act_cmpb_down = act_word[`PWMAD_F_CBD +: 2];

   // Comparator events, one direction at a time
   wire logic       cmpa_ev  = ev_cmpa_up | ev_cmpa_down;
   wire logic       cmpb_ev  = ev_cmpb_up | ev_cmpb_down;
   wire logic [1:0] cmpa_act = ev_cmpa_up ? act_cmpa_up : act_cmpa_down;
   wire logic [1:0] cmpb_act = ev_cmpb_up ? act_cmpb_up : act_cmpb_down;
   // Coincident comparators: A wins for output A, B for output B
   wire logic [1:0] both_act = PRIO_B ? cmpb_act : cmpa_act; // see (RULE_06) (RULE_07)

   // Zero and limit beat any comparator
   wire logic [1:0] sel_act  = ev_zero  ? act_on_empty : // see (RULE_05)
                               ev_limit ? act_on_limit :
                               (cmpa_ev && cmpb_ev) ? both_act :
                               cmpa_ev ? cmpa_act : cmpb_act;
   wire logic       any_ev   = ev_zero | ev_limit | cmpa_ev | cmpb_ev;
   wire logic       next_raw = apply_act(sel_act, raw_out); // see (RULE_03)

   // ----------------------------------------
   // Raw level register
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         raw_out <= 1'b0;
      else if (any_ev)
         raw_out <= next_raw; // see (RULE_19)
   end

endmodule

/* File: pwmad_chk.sv */
/* Port checker of the PWM action and dead-band stage.
   Assumes a bind onto pwmad_top, one clock domain. */
`timescale 1ns/1ps
module pwmad_chk
(
   // Clock and reset
   input wire logic        pclk,
   input wire logic        presetn,
   // APB
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic        pslverr,
   // PWM levels
   input wire logic        raw_out_a,
   input wire logic        raw_out_b,
   input wire logic        final_out_0,
   input wire logic        final_out_1
);
   // ------------------------------
   // Shadow state
   // ------------------------------
   logic        db_q, prev_a;
   logic [11:0] rise_q, fall_q;
   logic [15:0] age, run;
   wire         wr = psel && penable && pwrite;
   wire         ok = db_q && age > rise_q + 16'h8 && age > fall_q + 16'h8;

   // Age hides delayed edges launched before a rewrite
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         {db_q, prev_a, rise_q, fall_q, age, run} <= '0;
      else
      begin
         if (wr && paddr == 12'h068)
            db_q <= pwdata[0];
         if (wr && paddr == 12'h06c)
            rise_q <= pwdata[11:0];
         if (wr && paddr == 12'h070)
            fall_q <= pwdata[11:0];
         age <= (wr && paddr >= 12'h060) ? 16'h0 : age + {15'h0, age != 16'hffff};
         run <= (raw_out_a != prev_a) ? 16'h1 : run + {15'h0, run != 16'hffff};
         prev_a <= raw_out_a;
      end

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   property p_err;
      pslverr == (psel && penable && !(paddr inside {12'h040, 12'h050, 12'h054, 12'h058, 12'h05c,
         12'h060, 12'h064, 12'h068, 12'h06c, 12'h070, 12'h074}));
   endproperty
   a_err: assert property (p_err) else $error("pslverr wrong");
   property p_rst;
      $rose(presetn) |-> {raw_out_a, raw_out_b, final_out_0, final_out_1} == 4'h0;
   endproperty
   a_rst: assert property (p_rst) else $error("levels not low after reset");
   property p_pass0;
      !db_q && !$past(db_q) |-> final_out_0 == $past(raw_out_a);
   endproperty
   a_pass0: assert property (p_pass0) else $error("out0 not raw A");
   property p_pass1;
      !db_q && !$past(db_q) |-> final_out_1 == $past(raw_out_b);
   endproperty
   a_pass1: assert property (p_pass1) else $error("out1 not raw B");
   property p_rise;
      ok && $rose(final_out_0) |-> $past(raw_out_a, 2) && $past(run) == rise_q + 16'h1;
   endproperty
   a_rise: assert property (p_rise) else $error("out0 rise late or early");
   property p_fall;
      ok && $fell(final_out_1) |-> !$past(raw_out_a, 2) && $past(run) == fall_q + 16'h1;
   endproperty
   a_fall: assert property (p_fall) else $error("out1 fall late or early");
   property p_fall0;
      ok && $fell(raw_out_a) |-> ##2 !final_out_0;
   endproperty
   a_fall0: assert property (p_fall0) else $error("out0 fall missed");
   property p_rise1;
      ok && $rose(raw_out_a) |-> ##2 final_out_1;
   endproperty
   a_rise1: assert property (p_rise1) else $error("out1 rise missed");
endmodule

/* File: pwmad_edge_delay.sv */
/*
 * Delays one edge kind of a level by a programmed tick count.
 * RISE=1 delays rising edges, RISE=0 falling edges; the other edge
 * passes at once. Assumes level_in comes from a pclk flip-flop.
 */
`timescale 1ns/1ps
`include "pwmad_params.svh"

module pwmad_edge_delay
#(
   parameter bit RISE = 1'b1
)
(
   // Clock and reset
   input  wire logic                     pclk,
   input  wire logic                     presetn,
   // Control
   input  wire logic                     enable,
   input  wire logic [`PWMAD_DLY_W-1:0]  delay,
   // Level in and out
   input  wire logic                     level_in,
   output logic                          level_out
);

   logic                    prev_in;
   logic [`PWMAD_DLY_W-1:0] remain;

   // Edge toward the delayed level
   wire logic at_active = (level_in == RISE);
   wire logic edge_seen = at_active && (prev_in != RISE);
   wire logic dly_zero  = (delay == `PWMAD_DLY_ZERO);

   // ----------------------------------------
   // Countdown; leaving the active level early cancels the edge
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prev_in   <= ~RISE;
         remain    <= `PWMAD_DLY_ZERO;
         level_out <= ~RISE;
      end
      else if (!enable || !at_active)
      begin
         prev_in   <= level_in;
         remain    <= `PWMAD_DLY_ZERO;
         level_out <= ~RISE; // see (RULE_13) (RULE_14)
      end
      else if (edge_seen)
      begin
         prev_in <= level_in;
         if (dly_zero)
            level_out <= RISE; // see (RULE_20)
         else
            remain <= delay - `PWMAD_DLY_ONE; // see (RULE_20)
      end
      else if (remain == `PWMAD_DLY_ZERO)
         level_out <= RISE; // see (RULE_20)
      else
         remain <= remain - `PWMAD_DLY_ONE;
   end

endmodule

/* File: pwmad_params.svh */
/*
 * Register offsets, field positions, widths, reset values and small
 * constants of the PWM action and dead-band stage.
 * Assumes inclusion by bare name; holds definitions only.
 */
`ifndef PWMAD_PARAMS_SVH
`define PWMAD_PARAMS_SVH

// ----------------------------------------
// Register byte offsets (paddr[11:0])
// ----------------------------------------
`define PWMAD_OFF_GEN_CTRL   12'h040
`define PWMAD_OFF_LIMIT      12'h050
`define PWMAD_OFF_COUNT      12'h054
`define PWMAD_OFF_CMPA       12'h058
`define PWMAD_OFF_CMPB       12'h05c
`define PWMAD_OFF_GEN_A      12'h060
`define PWMAD_OFF_GEN_B      12'h064
`define PWMAD_OFF_DB_CTRL    12'h068
`define PWMAD_OFF_DB_RISE    12'h06c
`define PWMAD_OFF_DB_FALL    12'h070
`define PWMAD_OFF_STATUS     12'h074

// ----------------------------------------
// Widths
// ----------------------------------------
`define PWMAD_ADDR_W         12
`define PWMAD_CNT_W          16
`define PWMAD_ACT_W          12
`define PWMAD_DLY_W          12

// ----------------------------------------
// Field positions
// ----------------------------------------
`define PWMAD_RUN_BIT        0
`define PWMAD_MODE_BIT       1
`define PWMAD_DB_EN_BIT      0
`define PWMAD_F_ZERO         0
`define PWMAD_F_LIMIT        2
`define PWMAD_F_CAU          4
`define PWMAD_F_CAD          6
`define PWMAD_F_CBU          8
`define PWMAD_F_CBD          10

// ----------------------------------------
// Reset values and constants
// ----------------------------------------
`define PWMAD_RST_ACT        12'h000
`define PWMAD_RST_DLY        12'h000
`define PWMAD_RST_CNT        16'h0000
`define PWMAD_CNT_ONE        16'h0001
`define PWMAD_DLY_ZERO       12'h000
`define PWMAD_DLY_ONE        12'h001
`define PWMAD_WORD_ZERO      32'h0000_0000

`endif

/* File: pwmad_pkg.sv */
/*
 * Types shared by the PWM action and dead-band stage.
 * Assumes nothing of its surroundings.
 */
package pwmad_pkg;

   // Action field encodings
   typedef enum logic [1:0]
   {
      PWMAD_ACT_HOLD   = 2'h0,
      PWMAD_ACT_TOGGLE = 2'h1,
      PWMAD_ACT_LOW    = 2'h2,
      PWMAD_ACT_HIGH   = 2'h3
   } pwmad_action_t;

   // Counter direction state
   typedef enum logic
   {
      PWMAD_DIR_UP   = 1'b0,
      PWMAD_DIR_DOWN = 1'b1
   } pwmad_dir_t;

endpackage

/* File: pwmad_top.sv */
/*
 * PWM generator output stage: counter and comparator events, two
 * action generators and the dead-band unit, with an APB slave.
 * Assumes one 10 MHz clock pclk and an APB3 master on the same clock.
 */
// The APB interface to the registers was chosen for this implementation.
//
// Behaviour
// (RULE_01) Down mode yields four events; up/down mode yields all six.
// (RULE_02) Output A word: six 2-bit action fields, zero at bottom.
// (RULE_03) Codes: 00 hold, 01 toggle, 10 low, 11 high.
// (RULE_04) Up-match actions act only when the count-mode bit is 1.
// (RULE_05) Zero or limit action wins over coincident comparator action.
// (RULE_06) Output A: comparator A wins over comparator B.
// (RULE_07) Output B: comparator B wins over comparator A.
// (RULE_08) Output B word has the same layout and events.
// (RULE_09) Dead-band off: raw A to output 0, raw B to output 1.
// (RULE_10) Dead-band on: both outputs from raw A, rise and fall delayed.
// (RULE_11) Rise delay is a 12-bit tick count in bits 11:0.
// (RULE_12) Fall delay is a 12-bit tick count in bits 11:0.
// (RULE_13) Rise delay longer than high time removes the high pulse.
// (RULE_14) Fall delay longer than low time removes the low pulse.
// (RULE_15) Delay registers are ignored while dead-band is off.
// (RULE_16) Software keeps high and low times above the delays.
// (RULE_17) Counter pulses limit event at limit value, zero event at zero.
// (RULE_18) Comparators pulse direction-tagged matches, never above limit.
// (RULE_19) Raw outputs reset low, change only on a selected event.
// (RULE_20) Delays count down from each edge; zero delay adds nothing.
`timescale 1ns/1ps
`include "pwmad_params.svh"

module pwmad_top
(
   // Clock and reset
   input  wire logic                     pclk,
   input  wire logic                     presetn,
   // APB slave
   input  wire logic                     psel,
   input  wire logic                     penable,
   input  wire logic                     pwrite,
   input  wire logic [`PWMAD_ADDR_W-1:0] paddr,
   input  wire logic [31:0]              pwdata,
   output logic [31:0]                   prdata,
   output logic                          pready,
   output logic                          pslverr,
   // PWM levels
   output logic                          raw_out_a,
   output logic                          raw_out_b,
   output logic                          final_out_0,
   output logic                          final_out_1
);

   // ----------------------------------------
   // Helpers
   // ----------------------------------------

   // Zero-extend a count to a bus word
   function automatic logic [31:0] word16(input logic [`PWMAD_CNT_W-1:0] v);
      word16 = `PWMAD_WORD_ZERO | v;
   endfunction

   // Zero-extend an action or delay field to a bus word
   function automatic logic [31:0] word12(input logic [`PWMAD_ACT_W-1:0] v);
      word12 = `PWMAD_WORD_ZERO | v;
   endfunction

   // Comparator hit; a value above the limit never matches
   function automatic logic cmp_hit(input logic [`PWMAD_CNT_W-1:0] cnt,
                                    input logic [`PWMAD_CNT_W-1:0] val,
                                    input logic [`PWMAD_CNT_W-1:0] lim);
      cmp_hit = (cnt == val) && (val <= lim);
   endfunction

   // ----------------------------------------
   // Register storage
   // ----------------------------------------
   logic                    gen_run;
   logic                    gen_mode;
   logic [`PWMAD_CNT_W-1:0] counter_limit_value;
   logic [`PWMAD_CNT_W-1:0] cmpa_value;
   logic [`PWMAD_CNT_W-1:0] cmpb_value;
   logic [`PWMAD_ACT_W-1:0] gen_a_action_ctrl;
   logic [`PWMAD_ACT_W-1:0] gen_b_action_ctrl;
   logic                    db_enable;
   logic [`PWMAD_DLY_W-1:0] rise_edge_ticks;
   logic [`PWMAD_DLY_W-1:0] fall_edge_ticks;

   // Counter state
   logic [`PWMAD_CNT_W-1:0] count;
   pwmad_pkg::pwmad_dir_t   dir;

   // ----------------------------------------
   // APB decode
   // ----------------------------------------

   // Exact word addresses; unaligned or unlisted addresses miss
   wire logic hit_ctrl  = (paddr == `PWMAD_OFF_GEN_CTRL);
   wire logic hit_limit = (paddr == `PWMAD_OFF_LIMIT);
   wire logic hit_count = (paddr == `PWMAD_OFF_COUNT);
   wire logic hit_cmpa  = (paddr == `PWMAD_OFF_CMPA);
   wire logic hit_cmpb  = (paddr == `PWMAD_OFF_CMPB);
   wire logic hit_gen_a = (paddr == `PWMAD_OFF_GEN_A);
   wire logic hit_gen_b = (paddr == `PWMAD_OFF_GEN_B);
   wire logic hit_dbctl = (paddr == `PWMAD_OFF_DB_CTRL);
   wire logic hit_rise  = (paddr == `PWMAD_OFF_DB_RISE);
   wire logic hit_fall  = (paddr == `PWMAD_OFF_DB_FALL);
   wire logic hit_stat  = (paddr == `PWMAD_OFF_STATUS);
   wire logic hit_any   = hit_ctrl | hit_limit | hit_count | hit_cmpa |
                          hit_cmpb | hit_gen_a | hit_gen_b | hit_dbctl |
                          hit_rise | hit_fall | hit_stat;

   // Phases; no wait states, so the access phase always completes
   wire logic setup_ph  = psel & ~penable;
   wire logic access_ph = psel & penable;
   wire logic wr_en     = access_ph & pwrite & hit_any;

   // Handshake outputs are combinational
   assign pready  = 1'b1;
   assign pslverr = access_ph & ~hit_any;

   // Status word: live levels and direction
   wire logic [31:0] stat_word = {27'h0000000, dir, final_out_1, final_out_0,
                                  raw_out_b, raw_out_a};

   // Read mux
   wire logic [31:0] rd_word =
      hit_ctrl  ? {30'h00000000, gen_mode, gen_run} :
      hit_limit ? word16(counter_limit_value) :
      hit_count ? word16(count) :
      hit_cmpa  ? word16(cmpa_value) :
      hit_cmpb  ? word16(cmpb_value) :
      hit_gen_a ? word12(gen_a_action_ctrl) :
      hit_gen_b ? word12(gen_b_action_ctrl) :
      hit_dbctl ? {31'h00000000, db_enable} :
      hit_rise  ? word12(rise_edge_ticks) :
      hit_fall  ? word12(fall_edge_ticks) :
      hit_stat  ? stat_word :
      `PWMAD_WORD_ZERO;

   // Read data captured in setup so prdata comes from a flip-flop
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata <= `PWMAD_WORD_ZERO;
      else if (setup_ph && !pwrite)
         prdata <= rd_word;
   end

   // ----------------------------------------
   // Register writes
   // ----------------------------------------

   // Generator control and counter values; applied at once
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         gen_run             <= 1'b0;
         gen_mode            <= 1'b0;
         counter_limit_value <= `PWMAD_RST_CNT;
         cmpa_value          <= `PWMAD_RST_CNT;
         cmpb_value          <= `PWMAD_RST_CNT;
      end
      else if (wr_en)
      begin
         if (hit_ctrl)
         begin
            gen_run  <= pwdata[`PWMAD_RUN_BIT];
            gen_mode <= pwdata[`PWMAD_MODE_BIT];
         end
         if (hit_limit)
            counter_limit_value <= pwdata[`PWMAD_CNT_W-1:0];
         if (hit_cmpa)
            cmpa_value <= pwdata[`PWMAD_CNT_W-1:0];
         if (hit_cmpb)
            cmpb_value <= pwdata[`PWMAD_CNT_W-1:0];
      end
   end

   // Action words and dead-band settings
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         gen_a_action_ctrl <= `PWMAD_RST_ACT;
         gen_b_action_ctrl <= `PWMAD_RST_ACT;
         db_enable         <= 1'b0;
         rise_edge_ticks   <= `PWMAD_RST_DLY;
         fall_edge_ticks   <= `PWMAD_RST_DLY;
      end
      else if (wr_en)
      begin
         if (hit_gen_a)
            gen_a_action_ctrl <= pwdata[`PWMAD_ACT_W-1:0]; // see (RULE_02)
         if (hit_gen_b)
            gen_b_action_ctrl <= pwdata[`PWMAD_ACT_W-1:0]; // see (RULE_08)
         if (hit_dbctl)
            db_enable <= pwdata[`PWMAD_DB_EN_BIT];
         if (hit_rise)
            rise_edge_ticks <= pwdata[`PWMAD_DLY_W-1:0]; // see (RULE_11)
         if (hit_fall)
            fall_edge_ticks <= pwdata[`PWMAD_DLY_W-1:0]; // see (RULE_12)
      end
   end

   // ----------------------------------------
   // Counter
   // ----------------------------------------
   logic [`PWMAD_CNT_W-1:0] next_count;
   pwmad_pkg::pwmad_dir_t   next_dir;

   wire logic at_zero  = (count == `PWMAD_RST_CNT);
   wire logic at_limit = (count == counter_limit_value);

   // Down mode reloads at zero; up/down turns at the limit and at zero
   always_comb
   begin
      next_count = count;
      next_dir   = dir;
      if (!gen_mode)
      begin
         next_dir   = pwmad_pkg::PWMAD_DIR_DOWN;
         next_count = at_zero ? counter_limit_value : count - `PWMAD_CNT_ONE;
      end
      else
      begin
         case (dir)
            pwmad_pkg::PWMAD_DIR_UP:
            begin
               if (at_limit)
               begin
                  next_dir   = pwmad_pkg::PWMAD_DIR_DOWN;
                  next_count = at_zero ? count : count - `PWMAD_CNT_ONE;
               end
               else
                  next_count = count + `PWMAD_CNT_ONE;
            end
            pwmad_pkg::PWMAD_DIR_DOWN:
            begin
               if (at_zero)
               begin
                  next_dir   = pwmad_pkg::PWMAD_DIR_UP;
                  next_count = at_limit ? count : count + `PWMAD_CNT_ONE;
               end
               else
                  next_count = count - `PWMAD_CNT_ONE;
            end
            default:
            begin
               next_dir   = pwmad_pkg::PWMAD_DIR_UP;
               next_count = `PWMAD_RST_CNT;
            end
         endcase
      end
   end

   // Stopped counter parks at zero counting up
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         count <= `PWMAD_RST_CNT;
         dir   <= pwmad_pkg::PWMAD_DIR_UP;
      end
      else if (!gen_run)
      begin
         count <= `PWMAD_RST_CNT;
         dir   <= pwmad_pkg::PWMAD_DIR_UP;
      end
      else
      begin
         count <= next_count;
         dir   <= next_dir;
      end
   end

   // ----------------------------------------
   // Event pulses
   // ----------------------------------------

   // With a nonzero limit the count moves every cycle, so each match lasts one cycle
   wire logic ev_zero   = gen_run & at_zero; // see (RULE_17)
   wire logic ev_limit  = gen_run & at_limit; // see (RULE_17)
   wire logic hit_a     = gen_run & cmp_hit(count, cmpa_value, counter_limit_value); // see (RULE_18)
   wire logic hit_b     = gen_run & cmp_hit(count, cmpb_value, counter_limit_value); // see (RULE_18)
   wire logic going_up  = gen_mode & (dir == pwmad_pkg::PWMAD_DIR_UP);

   // Up-matches exist only in up/down mode
   wire logic ev_a_up   = hit_a & going_up; // see (RULE_01) (RULE_04)
   wire logic ev_a_down = hit_a & ~going_up; // see (RULE_01)
   wire logic ev_b_up   = hit_b & going_up; // see (RULE_01) (RULE_04)
   wire logic ev_b_down = hit_b & ~going_up; // see (RULE_01)

   // ----------------------------------------
   // Action generators
   // ----------------------------------------
   pwmad_action_gen #(.PRIO_B(1'b0)) u_gen_a // see (RULE_06)
   (
      .pclk         (pclk),
      .presetn      (presetn),
      .ev_zero      (ev_zero),
      .ev_limit     (ev_limit),
      .ev_cmpa_up   (ev_a_up),
      .ev_cmpa_down (ev_a_down),
      .ev_cmpb_up   (ev_b_up),
      .ev_cmpb_down (ev_b_down),
      .act_word     (gen_a_action_ctrl),
      .raw_out      (raw_out_a)
   );

   pwmad_action_gen #(.PRIO_B(1'b1)) u_gen_b // see (RULE_07) (RULE_08)
   (
      .pclk         (pclk),
      .presetn      (presetn),
      .ev_zero      (ev_zero),
      .ev_limit     (ev_limit),
      .ev_cmpa_up   (ev_a_up),
      .ev_cmpa_down (ev_a_down),
      .ev_cmpb_up   (ev_b_up),
      .ev_cmpb_down (ev_b_down),
      .act_word     (gen_b_action_ctrl),
      .raw_out      (raw_out_b)
   );

   // ----------------------------------------
   // Dead-band unit
   // ----------------------------------------
   logic rise_dly_out;
   logic fall_dly_out;

   // Both delays fed from raw A; held idle while disabled
   pwmad_edge_delay #(.RISE(1'b1)) u_rise
   (
      .pclk      (pclk),
      .presetn   (presetn),
      .enable    (db_enable), // see (RULE_15)
      .delay     (rise_edge_ticks),
      .level_in  (raw_out_a),
      .level_out (rise_dly_out)
   );

   pwmad_edge_delay #(.RISE(1'b0)) u_fall
   (
      .pclk      (pclk),
      .presetn   (presetn),
      .enable    (db_enable), // see (RULE_15)
      .delay     (fall_edge_ticks),
      .level_in  (raw_out_a),
      .level_out (fall_dly_out)
   );

   // Output select; the delay path is one flip-flop late already
   wire logic next_out_0 = db_enable ? rise_dly_out : raw_out_a; // see (RULE_09) (RULE_10)
   wire logic next_out_1 = db_enable ? fall_dly_out : raw_out_b; // see (RULE_09) (RULE_10)

   // Final outputs registered for clean pins
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         final_out_0 <= 1'b0;
         final_out_1 <= 1'b0;
      end
      else
      begin
         final_out_0 <= next_out_0;
         final_out_1 <= next_out_1;
      end
   end

endmodule
